// *** logic/ctm_addr_map.sv ***
// Purpose: geometry of the selected tag type: address, range, trailer
// Assumes: app/file come from the selection registers of the top
// Notes:   out-of-range requests map to address 0 and must be refused
`timescale 1ns/1ps
module ctm_addr_map #(
  parameter int PAGED_PAGES = 256
) (
  input  ctm_pkg::ctm_card_e card,
  input  logic [7:0]         index,
  input  logic [4:0]         app,
  input  logic [3:0]         file,
  output logic [8:0]         addr,
  output logic               inRange,
  output logic               trailer,
  output logic               readOnly,
  output logic [5:0]         sector
);
  import ctm_pkg::*;
  localparam logic [8:0] PAGED_LIM = 9'(PAGED_PAGES);
  always_comb begin
    addr     = {1'b0, index};
    inRange  = 1'b0;
    trailer  = 1'b0;
    readOnly = 1'b0;
    sector = (index < LARGE_SPLIT) ? index[7:2] : {3'b100, index[6:4]};
    case (card)
      CT_STD: begin
        inRange  = index < STD_BLOCKS;
        trailer  = ctm_is_trailer(index);
        readOnly = index == 8'h00;
      end
      CT_LARGE: begin
        inRange  = 1'b1;
        trailer  = ctm_is_trailer(index);
        readOnly = index == 8'h00;
      end
      CT_SMALL: inRange = index < SMALL_PAGES;
      CT_PAGED: begin
        inRange  = {1'b0, index} < PAGED_LIM;
        readOnly = index == 8'h00;
      end
      CT_APP: begin
        inRange = app < MAX_APPS;
        addr    = inRange ? {app, file} : 9'h000;
      end
      default: ;
    endcase
    if (!inRange)
      addr = 9'h000;
  end
endmodule

// *** logic/ctm_pkg.sv ***
// Purpose: shared types and constants of the contactless tag memory model
// Assumes: one tag in the field at a time, one memory array shared by types
// Notes:   block bytes are little endian, byte 0 in bits 7..0
package ctm_pkg;
  typedef enum logic [2:0] {
    CT_STD   = 3'h0,
    CT_SMALL = 3'h1,
    CT_LARGE = 3'h2,
    CT_APP   = 3'h3,
    CT_PAGED = 3'h4
  } ctm_card_e;
  typedef enum logic [3:0] {
    OP_SELECT  = 4'h0,
    OP_LOGIN   = 4'h1,
    OP_READ    = 4'h2,
    OP_WRITE   = 4'h3,
    OP_SELAPP  = 4'h4,
    OP_SELFILE = 4'h5,
    OP_COMMIT  = 4'h6,
    OP_ABORT   = 4'h7,
    OP_CONFIG  = 4'h8
  } ctm_op_e;
  typedef enum logic [4:0] {
    S_INIT   = 5'h01,
    S_IDLE   = 5'h02,
    S_ADDR   = 5'h04,
    S_EXEC   = 5'h08,
    S_COMMIT = 5'h10
  } ctm_state_e;
  localparam logic [2:0] ERR_NONE  = 3'h0;
  localparam logic [2:0] ERR_RANGE = 3'h1;
  localparam logic [2:0] ERR_RO    = 3'h2;
  localparam logic [2:0] ERR_AUTH  = 3'h3;
  localparam logic [2:0] ERR_FULL  = 3'h4;
  localparam logic [2:0] ERR_OP    = 3'h5;
  localparam logic [1:0] FM_PLAIN  = 2'h0;
  localparam int         MEM_DEPTH   = 448;
  localparam logic [7:0] STD_BLOCKS  = 8'h40;
  localparam logic [7:0] SMALL_PAGES = 8'h10;
  localparam logic [7:0] LARGE_SPLIT = 8'h80;
  localparam logic [7:0] LOGIN_DIR   = 8'h20;
  localparam logic [7:0] LOGIN_FIRST = 8'h24;
  localparam logic [7:0] LOGIN_LAST  = 8'h3c;
  localparam logic [5:0] SEC_SPLIT   = 6'h20;
  localparam logic [4:0] MAX_APPS    = 5'd28;
  localparam logic [7:0] MAX_KEYS    = 8'd14;
  localparam int KEYA_LSB = 0;
  localparam int KEYA_MSB = 47;
  localparam int ACC_LSB  = 48;
  localparam int ACC_MSB  = 71;
  localparam int KEYB_LSB = 80;
  localparam int KEYB_MSB = 127;
  localparam int SMALL_MSB = 31;
  localparam int PAGE_MSB  = 63;
  localparam logic [23:0] ACC_DELIVERY  = 24'h8007ff;
  localparam logic [47:0] TRANSPORT_KEY = 48'hffffffffffff;
  typedef struct packed {
    logic        valid;
    ctm_op_e     op;
    ctm_card_e   card;
    logic [7:0]  index;
    logic [4:0]  app;
    logic [3:0]  file;
    logic        keyB;
    logic [47:0] key;
    logic [127:0] data;
  } ctm_req_s;
  typedef struct packed {
    logic         done;
    logic [2:0]   err;
    logic [127:0] data;
  } ctm_rsp_s;
  // large-card login index to sector, msb flags a legal index
  function automatic logic [6:0] ctm_login_sector(input logic [7:0] idx);
    logic [7:0] d;
    d = (idx - LOGIN_DIR) >> 2;
    if (idx <= LOGIN_DIR)
      return {1'b1, idx[5:0]};
    else if (idx >= LOGIN_FIRST && idx <= LOGIN_LAST && idx[1:0] == 2'h0)
      return {1'b1, SEC_SPLIT + d[5:0]};
    return 7'h00;
  endfunction
  function automatic logic [8:0] ctm_trailer_addr(input logic [5:0] sec);
    if (sec < SEC_SPLIT)
      return {2'b00, sec[4:0], 2'h3};
    return {2'b01, sec[2:0], 4'hf};
  endfunction
  function automatic logic ctm_is_trailer(input logic [7:0] blk);
    return (blk < LARGE_SPLIT) ? (blk[1:0] == 2'h3) : (blk[3:0] == 4'hf);
  endfunction
endpackage

// *** logic/ctm_tag_memory.sv ***
// Purpose: contactless tag memory with the access semantics of each type
// Assumes: reader requests from clk domain; powerLoss is an async pin
// Notes:   memory is filled with delivery contents after every reset
// Operation
// - standard card: 16 sectors of four 16-byte blocks
// - block 0 is read-only: serial, check byte, maker data
// - sector trailer: primary key, access bytes, secondary key
// - enabled key fields read back as six zero bytes
// - delivery access FF 07 80: primary key only, secondary is data
// - small-page card: 16-byte slot, only 4 low bytes, plain text
// - large card: 4 blocks per sector below 20h, 16 from 20h
// - large login index: own below 21h, then 24h..3Ch by four
// - directory card: 28 applications, 16 files, 14 keys
// - directory card has 7-byte id, application 0 selected at start
// - file protection: plain, MAC, single or triple DES; every non-plain mode here only requires login
// - transactional file changes pend until commit
// - abort or power loss discards all pending changes
// - paged family: 8-byte pages, 16 to 256 pages, page 0 serial
`timescale 1ns/1ps
module ctm_tag_memory #(
  parameter int          PAGED_PAGES = 256,
  parameter int          PEND_DEPTH  = 4,
  parameter logic [31:0] SERIAL      = 32'h1a2b3c4d, // arbitrary value
  parameter logic [55:0] UID7        = 56'h11223344556677, // arbitrary
  parameter logic [87:0] MAKER       = 88'h0, // arbitrary value
  parameter logic [47:0] APP_KEY     = 48'h0
) (
  input  logic              clk,
  input  logic              reset,
  input  ctm_pkg::ctm_req_s req,
  input  logic              powerLoss,
  output logic              ready,
  output ctm_pkg::ctm_rsp_s rsp
);
  import ctm_pkg::*;
  if (PAGED_PAGES < 16 || PAGED_PAGES > 256 || PEND_DEPTH < 2) begin : g_chk
    $error("ctm_tag_memory: unsupported parameters");
  end
  localparam int CW = $clog2(PEND_DEPTH + 1);
  localparam int IW = $clog2(PEND_DEPTH);

  ctm_state_e   state;
  ctm_req_s     reqQ;
  ctm_card_e    curCard;
  logic [4:0]   curApp;
  logic [3:0]   selFile;
  logic         fileSel;
  logic         authValid;
  logic [5:0]   authSector;
  logic         appAuth;
  logic [8:0]   initCnt;
  logic [127:0] mem [0:MEM_DEPTH-1];
  logic [2:0]   fileCfg [0:MEM_DEPTH-1];
  logic [127:0] memQ;
  logic [8:0]   pendAddr [0:PEND_DEPTH-1];
  logic [127:0] pendData [0:PEND_DEPTH-1];
  logic [CW-1:0] pendCnt;
  logic [CW-1:0] commitIdx;
  logic         plSync1;
  logic         plSync2;
  logic [8:0]   mapAddr;
  logic         mapIn;
  logic         mapTrl;
  logic         mapRo;
  logic [5:0]   mapSec;
  logic [6:0]   logSec;
  logic [8:0]   rdAddr;
  logic         hit;
  logic [IW-1:0] hitIdx;
  logic [2:0]   eErr;
  logic [127:0] eData;
  logic         eWe;
  logic [127:0] eWd;
  logic         ePush;
  logic         eLogin;
  logic         memWe;
  logic [8:0]   memWa;
  logic [127:0] memWd;
  logic [127:0] initWord;
  logic         dlv;
  logic         exOk;

  ctm_addr_map #(.PAGED_PAGES(PAGED_PAGES)) u_map (
    .card    (curCard),
    .index   (reqQ.index),
    .app     (curApp),
    .file    (selFile),
    .addr    (mapAddr),
    .inRange (mapIn),
    .trailer (mapTrl),
    .readOnly(mapRo),
    .sector  (mapSec)
  );

  // power loss is asynchronous to clk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      plSync1 <= 1'b0;
      plSync2 <= 1'b0;
    end else begin
      plSync1 <= powerLoss;
      plSync2 <= plSync1;
    end
  end

  assign logSec = (curCard == CT_LARGE) ? ctm_login_sector(reqQ.index)
                : {reqQ.index < 8'h10, reqQ.index[5:0]};
  assign rdAddr = (reqQ.op == OP_LOGIN) ? ctm_trailer_addr(logSec[5:0])
                                        : mapAddr;
  assign dlv  = memQ[ACC_MSB:ACC_LSB] == ACC_DELIVERY;
  assign exOk = (state == S_EXEC) && (eErr == ERR_NONE);

  always_comb begin
    hit    = 1'b0;
    hitIdx = '0;
    for (int i = 0; i < PEND_DEPTH; i++) begin
      if (i < pendCnt && pendAddr[i] == mapAddr) begin
        hit    = 1'b1;
        hitIdx = IW'(i);
      end
    end
  end

  always_comb begin
    eErr   = ERR_NONE;
    eData  = memQ;
    eWe    = 1'b0;
    eWd    = reqQ.data;
    ePush  = 1'b0;
    eLogin = 1'b0;
    case (reqQ.op)
      // seven-byte id for the directory card
      OP_SELECT: eData = (reqQ.card == CT_APP) ? {72'h0, UID7}
                                               : {96'h0, SERIAL};
      OP_READ, OP_WRITE: begin
        if (!mapIn)
          eErr = ERR_RANGE;
        else if (reqQ.op == OP_WRITE && mapRo)
          eErr = ERR_RO;
        else begin
          case (curCard)
            CT_STD, CT_LARGE: begin
              if (!authValid || authSector != mapSec)
                eErr = ERR_AUTH;
              else if (reqQ.op == OP_WRITE)
                eWe = 1'b1;
              else if (mapTrl) begin
                eData[KEYA_MSB:KEYA_LSB] = '0;
                if (!dlv)
                  eData[KEYB_MSB:KEYB_LSB] = '0;
              end
            end
            CT_SMALL: begin
              eData = {96'h0, memQ[SMALL_MSB:0]};
              eWd   = {96'h0, reqQ.data[SMALL_MSB:0]};
              eWe   = reqQ.op == OP_WRITE;
            end
            CT_PAGED: begin
              eData = {64'h0, memQ[PAGE_MSB:0]};
              eWd   = {64'h0, reqQ.data[PAGE_MSB:0]};
              eWe   = reqQ.op == OP_WRITE;
            end
            CT_APP: begin
              if (!fileSel)
                eErr = ERR_OP;
              else if (fileCfg[mapAddr][1:0] != FM_PLAIN && !appAuth)
                eErr = ERR_AUTH;
              else if (reqQ.op == OP_WRITE) begin
                if (!fileCfg[mapAddr][2])
                  eWe = 1'b1;
                else if (!hit && pendCnt == CW'(PEND_DEPTH))
                  eErr = ERR_FULL;
                else
                  ePush = 1'b1;
              end
            end
            default: eErr = ERR_OP;
          endcase
        end
      end
      OP_LOGIN: begin
        case (curCard)
          CT_STD, CT_LARGE: begin
            if (!logSec[6])
              eErr = ERR_RANGE;
            // key fields around the access bytes
            else if (reqQ.keyB ? (dlv || reqQ.key != memQ[KEYB_MSB:KEYB_LSB])
                               : reqQ.key != memQ[KEYA_MSB:KEYA_LSB])
              eErr = ERR_AUTH;
            else
              eLogin = 1'b1;
          end
          CT_APP: begin
            if (reqQ.index >= MAX_KEYS || reqQ.key != APP_KEY)
              eErr = ERR_AUTH;
            else
              eLogin = 1'b1;
          end
          default: eErr = ERR_OP;
        endcase
      end
      OP_SELAPP: begin
        if (curCard != CT_APP)
          eErr = ERR_OP;
        else if (reqQ.app >= MAX_APPS)
          eErr = ERR_RANGE;
      end
      OP_SELFILE, OP_COMMIT, OP_ABORT: begin
        if (curCard != CT_APP)
          eErr = ERR_OP;
      end
      OP_CONFIG: begin
        if (curCard != CT_APP || !fileSel)
          eErr = ERR_OP;
        else if (!appAuth)
          eErr = ERR_AUTH;
      end
      default: eErr = ERR_OP;
    endcase
    // no echo of keys
    // login reads the trailer internally; only read and select hand data out
    if (reqQ.op != OP_READ && reqQ.op != OP_SELECT)
      eData = '0;
  end

  // delivery image: serial in block 0, transport keys in every trailer
  always_comb begin
    initWord = '0;
    if (initCnt == 9'h000)
      initWord = {MAKER, SERIAL[31:24] ^ SERIAL[23:16] ^ SERIAL[15:8]
                  ^ SERIAL[7:0], SERIAL};
    else if (initCnt < 9'h100 && ctm_is_trailer(initCnt[7:0]))
      initWord = {TRANSPORT_KEY, 8'h00, ACC_DELIVERY, TRANSPORT_KEY};
  end

  always_comb begin
    memWe = 1'b0;
    memWa = mapAddr;
    memWd = eWd;
    if (state == S_INIT) begin
      memWe = 1'b1;
      memWa = initCnt;
      memWd = initWord;
    end else if (exOk && eWe)
      memWe = 1'b1;
    else if (state == S_COMMIT && commitIdx < pendCnt) begin
      memWe = 1'b1;
      memWa = pendAddr[commitIdx[IW-1:0]];
      memWd = pendData[commitIdx[IW-1:0]];
    end
  end

  always_ff @(posedge clk) begin
    memQ <= mem[rdAddr];
    if (memWe)
      mem[memWa] <= memWd;
    if (state == S_INIT)
      fileCfg[initCnt] <= 3'h0;
    else if (exOk && reqQ.op == OP_CONFIG)
      fileCfg[mapAddr] <= reqQ.data[2:0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state   <= S_INIT;
      ready   <= 1'b0;
      rsp     <= '0;
      reqQ    <= '0;
      initCnt <= 9'h000;
    end else begin
      case (state)
        S_INIT: begin
          initCnt <= initCnt + 9'h001;
          if (initCnt == 9'(MEM_DEPTH - 1)) begin
            state <= S_IDLE;
            ready <= 1'b1;
          end
        end
        S_IDLE: begin
          rsp.done <= 1'b0;
          if (req.valid) begin
            reqQ  <= req;
            ready <= 1'b0;
            state <= S_ADDR;
          end
        end
        S_ADDR: state <= S_EXEC;
        S_EXEC: begin
          if (exOk && reqQ.op == OP_COMMIT)
            state <= S_COMMIT;
          else begin
            rsp   <= '{done: 1'b1, err: eErr,
                       data: (eErr == ERR_NONE) ? eData : '0};
            ready <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_COMMIT: begin
          if (commitIdx >= pendCnt) begin
            rsp   <= '{done: 1'b1, err: ERR_NONE, data: '0};
            ready <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // selection and login context
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      curCard    <= CT_STD;
      curApp     <= 5'h00;
      selFile    <= 4'h0;
      fileSel    <= 1'b0;
      authValid  <= 1'b0;
      authSector <= 6'h00;
      appAuth    <= 1'b0;
    end else if (plSync2) begin
      authValid <= 1'b0;
      appAuth   <= 1'b0;
    end else if (exOk) begin
      case (reqQ.op)
        OP_SELECT: begin
          curCard   <= reqQ.card;
          curApp    <= 5'h00;
          fileSel   <= 1'b0;
          authValid <= 1'b0;
          appAuth   <= 1'b0;
        end
        OP_LOGIN: begin
          authValid  <= eLogin && curCard != CT_APP;
          authSector <= logSec[5:0];
          appAuth    <= eLogin && curCard == CT_APP;
        end
        OP_SELAPP: begin
          curApp  <= reqQ.app;
          fileSel <= 1'b0;
          appAuth <= 1'b0;
        end
        OP_SELFILE: begin
          selFile <= reqQ.file;
          fileSel <= 1'b1;
        end
        default: ;
      endcase
    end else if (state == S_EXEC && reqQ.op == OP_LOGIN) begin
      authValid <= 1'b0;
      appAuth   <= 1'b0;
    end
  end

  // pending transaction buffer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pendCnt   <= '0;
      commitIdx <= '0;
    end else begin
      commitIdx <= (state == S_COMMIT) ? commitIdx + CW'(1) : '0;
      // abort, reselect or power loss discards
      if (plSync2 || (state == S_COMMIT && commitIdx >= pendCnt))
        pendCnt <= '0;
      else if (exOk && (reqQ.op == OP_ABORT || reqQ.op == OP_SELAPP
                        || reqQ.op == OP_SELECT))
        pendCnt <= '0;
      else if (exOk && ePush && !hit)
        pendCnt <= pendCnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (exOk && ePush) begin
      pendAddr[hit ? hitIdx : pendCnt[IW-1:0]] <= mapAddr;
      pendData[hit ? hitIdx : pendCnt[IW-1:0]] <= eWd;
    end
  end

  AST_BLOCK0_RO: assert property (@(posedge clk) disable iff (reset)
    state == S_EXEC && reqQ.op == OP_WRITE && curCard == CT_STD
    && reqQ.index == 8'h00 |=> rsp.done && rsp.err == ERR_RO)
    else $error("block 0 write not refused");
  AST_KEY_MASK: assert property (@(posedge clk) disable iff (reset)
    exOk && reqQ.op == OP_READ && mapTrl && curCard == CT_STD
    |=> rsp.data[KEYA_MSB:KEYA_LSB] == '0)
    else $error("primary key leaked on read");
  AST_KEYB_DATA: assert property (@(posedge clk) disable iff (reset)
    exOk && reqQ.op == OP_READ && mapTrl && dlv
    |=> rsp.data[KEYB_MSB:KEYB_LSB] == $past(memQ[KEYB_MSB:KEYB_LSB]))
    else $error("secondary key not returned as data");
  AST_SMALL_HI: assert property (@(posedge clk) disable iff (reset)
    rsp.done && reqQ.op == OP_READ && curCard == CT_SMALL
    |-> rsp.data[127:32] == '0)
    else $error("small-page upper bytes not zero");
  AST_STD_RANGE: assert property (@(posedge clk)
    disable iff (reset)
    state == S_EXEC && curCard == CT_STD && reqQ.op == OP_WRITE
    && reqQ.index >= STD_BLOCKS |-> !memWe ##1 rsp.err == ERR_RANGE)
    else $error("out-of-range write not refused");
  AST_LOGIN_XLAT: assert property (@(posedge clk)
    disable iff (reset)
    exOk && reqQ.op == OP_LOGIN && curCard == CT_LARGE
    && reqQ.index == 8'h24 |=> authValid && authSector == 6'h21)
    else $error("login index 24h not sector 21h");
  AST_LARGE_SEC: assert property (@(posedge clk) disable iff (reset)
    curCard == CT_LARGE && reqQ.index == 8'h8f |-> mapSec == 6'h20 && mapTrl)
    else $error("block 8Fh not trailer of sector 20h");
  AST_PEND_HOLD: assert property (@(posedge clk)
    disable iff (reset)
    exOk && ePush && !hit && !plSync2
    |-> !memWe ##1 pendCnt == $past(pendCnt) + CW'(1))
    else $error("transactional write not held");
  AST_ABORT: assert property (@(posedge clk) disable iff (reset)
    rsp.done && reqQ.op == OP_ABORT && rsp.err == ERR_NONE |-> pendCnt == '0)
    else $error("abort left pending changes");
  AST_APP_LIMIT: assert property (@(posedge clk)
    disable iff (reset)
    state == S_EXEC && curCard == CT_APP && reqQ.op == OP_SELAPP
    && reqQ.app >= MAX_APPS |=> rsp.err == ERR_RANGE)
    else $error("application beyond limit accepted");
  COV_LOGIN_READ: cover property (@(posedge clk) disable iff (reset)
    rsp.done && reqQ.op == OP_READ && rsp.err == ERR_NONE && authValid);
  COV_COMMIT: cover property (@(posedge clk) disable iff (reset)
    state == S_COMMIT && memWe);
  COV_LARGE_LOGIN: cover property (@(posedge clk) disable iff (reset)
    exOk && reqQ.op == OP_LOGIN && curCard == CT_LARGE && logSec[5:0] > 6'h20);
endmodule

// *** verif/ctm_reader_model.sv ***
// Purpose: reader that selects, logs in, reads and writes, one at a time
// Assumes: caller stands on a falling edge; request taken at the next rise
// Notes:   released key and data show inverted values, never the last value
`timescale 1ns/1ps
module ctm_reader_model (
  input  logic              clk,
  input  logic              ready,
  input  ctm_pkg::ctm_rsp_s rsp,
  output ctm_pkg::ctm_req_s req,
  output logic              hung
);
  import ctm_pkg::*;
  initial begin
    req = '0;
    hung = 1'b0;
  end
  // trailers never written; select comes first
  task automatic xfer(input ctm_card_e c, input ctm_op_e o,
                      input logic [7:0] i, input logic [127:0] d,
                      output ctm_rsp_s r);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (ready !== 1'b1)
      hung = 1'b1;
    // key type rides on the top data bit, key on the low 48 bits
    req = '{1'b1, o, c, i, i[4:0], i[3:0], d[127], d[47:0], d};
    @(negedge clk);
    req.valid = 1'b0;
    req.key = ~req.key;
    req.data = ~req.data;
    n = 0;
    while (rsp.done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (rsp.done !== 1'b1)
      hung = 1'b1;
    r = rsp;
  endtask
endmodule

// *** verif/ctm_tag_memory_test.sv ***
// Purpose: self-checking bench of the tag memory, one task per scenario
// Assumes: inputs change on the falling edge; paged card shrunk to 16 pages
// Notes:   unknown stored content is read first, never assumed
`timescale 1ns/1ps
module ctm_tag_memory_test;
  import ctm_pkg::*;
  localparam logic [31:0]  SER  = 32'h5a6b7c8d; // arbitrary value
  localparam logic [55:0]  UID  = 56'h0102030405060e; // arbitrary value
  localparam logic [87:0]  MKR  = 88'h123; // arbitrary value
  localparam logic [47:0]  AKEY = 48'h0c0c0c0c0c0c; // arbitrary value
  localparam logic [127:0] PAT  = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] TK   = {80'h0, TRANSPORT_KEY};
  localparam logic [127:0] TRL  = {TRANSPORT_KEY, 32'h008007ff, 48'h0};
  logic      clk = 1'b0;
  logic      reset = 1'b1;
  logic      powerLoss = 1'b0;
  logic      ready;
  logic      hung;
  ctm_req_s  req;
  ctm_rsp_s  rsp;
  ctm_rsp_s  r;
  ctm_card_e cur = CT_STD;
  int        n_errors = 0;
  int        checked = 0;
  always #20 clk = ~clk;
  ctm_tag_memory #(.PAGED_PAGES(16), .SERIAL(SER), .UID7(UID), .MAKER(MKR),
    .APP_KEY(AKEY)) DUT (.clk(clk), .reset(reset), .req(req),
    .powerLoss(powerLoss), .ready(ready), .rsp(rsp));
  ctm_reader_model rd (.clk(clk), .ready(ready), .rsp(rsp), .req(req),
    .hung(hung));
  task automatic results();
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge hung) begin
    n_errors++;
    results();
  end
  task automatic chk(input string nm, input logic [127:0] x,
                     input logic [127:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic t(input string nm, input ctm_op_e o, input logic [7:0] i,
                   input logic [127:0] d, input logic [2:0] e);
    rd.xfer(cur, o, i, d, r);
    chk(nm, {125'h0, e}, {125'h0, r.err});
    chk("ready", 128'h1, {127'h0, ready});
  endtask
  task automatic rdc(input string nm, input logic [7:0] i,
                     input logic [127:0] x);
    t(nm, OP_READ, i, '0, ERR_NONE);
    chk(nm, x, r.data);
  endtask
  task automatic std_card();
    cur = CT_STD;
    t("sel", OP_SELECT, 8'h00, '0, ERR_NONE);
    chk("serial", {96'h0, SER}, r.data);
    t("lg0", OP_LOGIN, 8'h00, TK, ERR_NONE);
    chk("lgkey", 128'h0, r.data);
    rdc("blk0", 8'h00, {MKR, SER[31:24] ^ SER[23:16] ^ SER[15:8] ^ SER[7:0],
      SER});
    t("wr0", OP_WRITE, 8'h00, PAT, ERR_RO);
    t("lg1", OP_LOGIN, 8'h01, TK, ERR_NONE);
    t("wr6", OP_WRITE, 8'h06, PAT, ERR_NONE);
    rdc("rd6", 8'h06, PAT);
    rdc("trl7", 8'h07, TRL);
    t("oor", OP_READ, 8'h40, '0, ERR_RANGE);
    t("oorw", OP_WRITE, 8'h40, PAT, ERR_RANGE);
    t("lg16", OP_LOGIN, 8'h10, TK, ERR_RANGE);
    t("keyb", OP_LOGIN, 8'h01, {1'b1, TK[126:0]}, ERR_AUTH);
    t("noauth", OP_READ, 8'h06, '0, ERR_AUTH);
  endtask
  task automatic small_card();
    cur = CT_SMALL;
    t("ssel", OP_SELECT, 8'h00, '0, ERR_NONE);
    t("sapp", OP_SELAPP, 8'h00, '0, ERR_OP);
    t("srd", OP_READ, 8'h05, '0, ERR_NONE);
    // unused bytes refilled from the last read response, which holds zeros there
    t("swr", OP_WRITE, 8'h05, {r.data[127:32], 32'hc0ffee11}, ERR_NONE);
    rdc("s5", 8'h05, {96'h0, 32'hc0ffee11});
    t("s16", OP_READ, 8'h10, '0, ERR_RANGE);
  endtask
  task automatic large_card();
    cur = CT_LARGE;
    t("lsel", OP_SELECT, 8'h00, '0, ERR_NONE);
    t("lw0", OP_WRITE, 8'h00, PAT, ERR_RO);
    t("l24", OP_LOGIN, 8'h24, TK, ERR_NONE);
    t("w90", OP_WRITE, 8'h90, ~PAT, ERR_NONE);
    rdc("r90", 8'h90, ~PAT);
    rdc("r9f", 8'h9f, TRL);
    t("r8f", OP_READ, 8'h8f, '0, ERR_AUTH);
    t("l3c", OP_LOGIN, 8'h3c, TK, ERR_NONE);
    rdc("rff", 8'hff, TRL);
    t("l25", OP_LOGIN, 8'h25, TK, ERR_RANGE);
    t("l40", OP_LOGIN, 8'h40, TK, ERR_RANGE);
  endtask
  task automatic app_card();
    logic [127:0] old;
    cur = CT_APP;
    t("asel", OP_SELECT, 8'h00, '0, ERR_NONE);
    chk("uid", {72'h0, UID}, r.data);
    t("afile", OP_SELFILE, 8'h01, '0, ERR_NONE);
    t("k13", OP_LOGIN, 8'h0d, {80'h0, AKEY}, ERR_NONE);
    t("k14", OP_LOGIN, 8'h0e, {80'h0, AKEY}, ERR_AUTH);
    t("k0", OP_LOGIN, 8'h00, {80'h0, AKEY}, ERR_NONE);
    for (int m = 1; m < 4; m++) begin
      t("cfg", OP_CONFIG, 8'h01, 128'(m), ERR_NONE);
      t("badkey", OP_LOGIN, 8'h00, '0, ERR_AUTH);
      t("wprot", OP_WRITE, 8'h01, PAT, ERR_AUTH);
      t("k0", OP_LOGIN, 8'h00, {80'h0, AKEY}, ERR_NONE);
    end
    t("cfgt", OP_CONFIG, 8'h01, 128'h4, ERR_NONE);
    t("old", OP_READ, 8'h01, '0, ERR_NONE);
    old = r.data;
    t("wa", OP_WRITE, 8'h01, PAT, ERR_NONE);
    rdc("pend", 8'h01, old);
    t("abort", OP_ABORT, 8'h01, '0, ERR_NONE);
    t("cm0", OP_COMMIT, 8'h01, '0, ERR_NONE);
    rdc("aborted", 8'h01, old);
    t("wa2", OP_WRITE, 8'h01, PAT, ERR_NONE);
    t("cm1", OP_COMMIT, 8'h01, '0, ERR_NONE);
    rdc("commit", 8'h01, PAT);
    t("wb", OP_WRITE, 8'h01, ~PAT, ERR_NONE);
    powerLoss = 1'b1;
    repeat (4) @(negedge clk);
    powerLoss = 1'b0;
    repeat (3) @(negedge clk);
    t("cm2", OP_COMMIT, 8'h01, '0, ERR_NONE);
    rdc("lost", 8'h01, PAT);
    t("app28", OP_SELAPP, 8'h1c, '0, ERR_RANGE);
    t("app27", OP_SELAPP, 8'h1b, '0, ERR_NONE);
    t("nofile", OP_READ, 8'h01, '0, ERR_OP);
    t("f27", OP_SELFILE, 8'h01, '0, ERR_NONE);
    rdc("a27", 8'h01, '0);
  endtask
  task automatic paged_card();
    cur = CT_PAGED;
    t("psel", OP_SELECT, 8'h00, '0, ERR_NONE);
    t("pw0", OP_WRITE, 8'h00, PAT, ERR_RO);
    t("p16", OP_READ, 8'h10, '0, ERR_RANGE);
    t("pw15", OP_WRITE, 8'h0f, {64'h0, PAT[63:0]}, ERR_NONE);
    rdc("pr15", 8'h0f, {64'h0, PAT[63:0]});
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    std_card();
    small_card();
    large_card();
    app_card();
    paged_card();
    results();
  end
endmodule
